// >>> pmw_map.svh
// register and port constants for the planar memory write block
// assumes: included by the core by bare name
`ifndef PMW_MAP_SVH
`define PMW_MAP_SVH
// ==========================================================
// i/o ports of the graphics index/data pair
`define PMW_IO_INDEX 16'h03CE
`define PMW_IO_DATA 16'h03CF
// ==========================================================
// register indices behind the data port
`define PMW_IDX_SET_RESET 8'h00
`define PMW_IDX_SR_ENABLE 8'h01
`define PMW_IDX_ROTATE 8'h03
`define PMW_IDX_MODE 8'h05
`define PMW_IDX_MISC 8'h06
`define PMW_IDX_BIT_MASK 8'h08
// ==========================================================
// field positions
`define PMW_MODE_WM_LSB 0
`define PMW_MISC_GMS_BIT 0
`define PMW_MISC_OES_BIT 1
`define PMW_MISC_MAP_LSB 2
// ==========================================================
// reset values
`define PMW_RST_REG 8'h00
// ==========================================================
// cpu window codes and bases
`define PMW_MAP_128K 2'h0
`define PMW_MAP_64K 2'h1
`define PMW_MAP_32K_LO 2'h2
`define PMW_MAP_32K_HI 2'h3
`define PMW_BASE_A 3'h5
`define PMW_BASE_A64 4'hA
`define PMW_BASE_B0 5'h16
`define PMW_BASE_B8 5'h17
`endif

// >>> pmw_pkg.sv
// types shared by the planar memory write block
// assumes: pmw_map.svh sits in the same folder
package pmw_pkg;
  // ==========================================================
  // write modes
  typedef enum logic [1:0] {
    PMW_WM_SR_ROT = 2'b00,
    PMW_WM_LATCH = 2'b01,
    PMW_WM_EXPAND = 2'b10,
    PMW_WM_SR_MASK = 2'b11
  } pmw_wmode_t;
  // ==========================================================
  // i/o cycle from the cpu
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pmw_io_req_t;
  // cpu memory cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [19:0] addr;
    logic [7:0] wdata;
  } pmw_cpu_req_t;
  // request to the four planes
  typedef struct packed {
    logic wr;
    logic rd;
    logic [16:0] addr;
    logic [3:0] plane_en;
    logic [31:0] wdata;
  } pmw_vmem_req_t;
endpackage

// >>> pmw_core.sv
// planar memory write core: graphics registers, write modes, cpu window
// assumes: one 200 MHz core_clk, synchronous inputs, plane memory outside
//
// Summary of operation
// RULE1: the low two bits of the mode register pick one of four write modes.
// RULE2: in mode 0 a plane with set/reset enabled takes its set/reset bit, others rotated data.
// RULE3: in mode 1 every plane is written with the latches from the last memory read.
// RULE4: in mode 1 set/reset, its enables and the bit mask have no effect.
// RULE5: in mode 2 plane n takes cpu data bit n on all bits, then goes through the bit mask.
// RULE6: in mode 3 each plane takes its set/reset bit, enabled by bit mask and rotated data.
// RULE7: a bit whose mask is 0 takes the latch bit in every plane, others the mode result.
// RULE8: misc bits 3:2 choose which cpu address window decodes as video memory.
// RULE9: with odd/even off, cpu address bit 0 goes straight to memory address bit 0.
// RULE10: with odd/even on, memory address bit 0 comes from a higher bit and cpu bit 0 steers maps.
// RULE11: in odd/even, cpu bit 0 low hits maps 0 and 2, high hits maps 1 and 3.
// RULE12: misc bit 0 selects text addressing when 0 and graphics when 1.
`timescale 1ns/1ps
`include "pmw_map.svh"

module pmw_core
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pmw_pkg::pmw_io_req_t io_req,
  output logic [7:0] io_rdata,
  input wire pmw_pkg::pmw_cpu_req_t cpu_req,
  input wire logic vmem_rvalid,
  input wire logic [31:0] vmem_rdata,
  output pmw_pkg::pmw_vmem_req_t vmem_req,
  output logic cpu_hit,
  output logic text_or_graphics_select
);
  import pmw_pkg::*;

  // ==========================================================
  // helper functions

  // rotate right, used for cpu data in modes 0 and 3
  function automatic logic [7:0] pmw_rotr(input logic [7:0] d, input logic [2:0] n);
    logic [15:0] w;
    w = {d, d} >> n;
    return w[7:0];
  endfunction

  // window decode: hit flag and 17-bit window offset
  function automatic logic [17:0] pmw_decode(input logic [1:0] map, input logic [19:0] a);
    logic hit;
    logic [16:0] off;
    hit = 1'b0;
    off = 17'h00000;
    unique case (map)
      `PMW_MAP_128K:
      begin
        hit = (a[19:17] == `PMW_BASE_A);
        off = a[16:0];
      end
      `PMW_MAP_64K:
      begin
        hit = (a[19:16] == `PMW_BASE_A64);
        off = {1'b0, a[15:0]};
      end
      `PMW_MAP_32K_LO:
      begin
        hit = (a[19:15] == `PMW_BASE_B0);
        off = {2'b00, a[14:0]};
      end
      `PMW_MAP_32K_HI:
      begin
        hit = (a[19:15] == `PMW_BASE_B8);
        off = {2'b00, a[14:0]};
      end
    endcase
    return {hit, off};
  endfunction

  // ==========================================================
  // register file
  logic [7:0] index_reg;
  logic [7:0] set_reset;
  logic [7:0] sr_enable;
  logic [7:0] rotate;
  logic [7:0] mode;
  logic [7:0] graphics_misc_control;
  logic [7:0] bit_mask;
  logic [7:0] io_rdata_q;
  logic [7:0] next_index_reg;
  logic [7:0] next_set_reset;
  logic [7:0] next_sr_enable;
  logic [7:0] next_rotate;
  logic [7:0] next_mode;
  logic [7:0] next_misc;
  logic [7:0] next_bit_mask;
  logic [7:0] next_io_rdata;
  logic data_wr;

  // index port write, data port write to the indexed register
  always_comb
  begin
    next_index_reg = index_reg;
    next_set_reset = set_reset;
    next_sr_enable = sr_enable;
    next_rotate = rotate;
    next_mode = mode;
    next_misc = graphics_misc_control;
    next_bit_mask = bit_mask;
    next_io_rdata = io_rdata_q;
    data_wr = io_req.wr && (io_req.addr == `PMW_IO_DATA);
    if (io_req.wr && (io_req.addr == `PMW_IO_INDEX))
      next_index_reg = io_req.wdata;
    if (data_wr)
    begin
      unique case (index_reg)
        `PMW_IDX_SET_RESET: next_set_reset = {4'h0, io_req.wdata[3:0]};
        `PMW_IDX_SR_ENABLE: next_sr_enable = {4'h0, io_req.wdata[3:0]};
        `PMW_IDX_ROTATE: next_rotate = {5'h00, io_req.wdata[2:0]};
        `PMW_IDX_MODE: next_mode = {6'h00, io_req.wdata[1:0]}; // [RULE1]
        `PMW_IDX_MISC: next_misc = {4'h0, io_req.wdata[3:0]}; // reserved bits read zero
        `PMW_IDX_BIT_MASK: next_bit_mask = io_req.wdata;
        default: next_misc = graphics_misc_control; // unmapped index ignored
      endcase
    end
    // read data is held until the next i/o read
    if (io_req.rd)
    begin
      if (io_req.addr == `PMW_IO_INDEX)
        next_io_rdata = index_reg;
      else if (io_req.addr == `PMW_IO_DATA)
      begin
        unique case (index_reg)
          `PMW_IDX_SET_RESET: next_io_rdata = set_reset;
          `PMW_IDX_SR_ENABLE: next_io_rdata = sr_enable;
          `PMW_IDX_ROTATE: next_io_rdata = rotate;
          `PMW_IDX_MODE: next_io_rdata = mode;
          `PMW_IDX_MISC: next_io_rdata = graphics_misc_control;
          `PMW_IDX_BIT_MASK: next_io_rdata = bit_mask;
          default: next_io_rdata = 8'h00;
        endcase
      end
      else
        next_io_rdata = 8'h00;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      index_reg <= `PMW_RST_REG;
      set_reset <= `PMW_RST_REG;
      sr_enable <= `PMW_RST_REG;
      rotate <= `PMW_RST_REG;
      mode <= `PMW_RST_REG;
      graphics_misc_control <= `PMW_RST_REG;
      bit_mask <= `PMW_RST_REG;
      io_rdata_q <= `PMW_RST_REG;
    end
    else
    begin
      index_reg <= next_index_reg;
      set_reset <= next_set_reset;
      sr_enable <= next_sr_enable;
      rotate <= next_rotate;
      mode <= next_mode;
      graphics_misc_control <= next_misc;
      bit_mask <= next_bit_mask;
      io_rdata_q <= next_io_rdata;
    end
  end

  assign io_rdata = io_rdata_q;
  // text/graphics select is the misc flop itself
  assign text_or_graphics_select = graphics_misc_control[`PMW_MISC_GMS_BIT]; // [RULE12]

  // ==========================================================
  // processor latches
  logic [31:0] latch;
  logic [31:0] next_latch;

  // loaded by every plane read so mode 1 and the mask see the last read
  always_comb
  begin
    next_latch = latch;
    if (vmem_rvalid)
      next_latch = vmem_rdata; // [RULE3]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      latch <= 32'h00000000;
    else
      latch <= next_latch;
  end

  // ==========================================================
  // write data path and address mapping
  pmw_vmem_req_t vmem_q;
  pmw_vmem_req_t next_vmem;
  logic hit_q;
  logic next_hit;
  pmw_wmode_t wmode;
  logic [7:0] rot_data;
  logic [7:0] mode_data;
  logic [7:0] ena;
  logic [17:0] dec;
  logic [16:0] off;
  logic odd_even;

  always_comb
  begin
    wmode = pmw_wmode_t'(mode[`PMW_MODE_WM_LSB +: 2]);
    rot_data = pmw_rotr(cpu_req.wdata, rotate[2:0]);
    dec = pmw_decode(graphics_misc_control[`PMW_MISC_MAP_LSB +: 2], cpu_req.addr); // [RULE8]
    off = dec[16:0];
    odd_even = graphics_misc_control[`PMW_MISC_OES_BIT];
    next_hit = dec[17] && (cpu_req.wr || cpu_req.rd);
    next_vmem = '0;
    next_vmem.wr = cpu_req.wr && dec[17];
    next_vmem.rd = cpu_req.rd && dec[17];
    mode_data = 8'h00;
    ena = 8'h00;
    // per plane: mode result, then mask bits 0 fall back to the latch
    for (int p = 0; p < 4; p++)
    begin
      unique case (wmode)
        PMW_WM_SR_ROT:
        begin
          mode_data = sr_enable[p] ? {8{set_reset[p]}} : rot_data; // [RULE2]
          ena = bit_mask;
        end
        PMW_WM_LATCH:
        begin
          mode_data = latch[p*8 +: 8]; // [RULE3]
          ena = 8'hFF; // mask and set/reset play no part [RULE4]
        end
        PMW_WM_EXPAND:
        begin
          mode_data = {8{cpu_req.wdata[p]}}; // [RULE5]
          ena = bit_mask;
        end
        PMW_WM_SR_MASK:
        begin
          mode_data = {8{set_reset[p]}}; // [RULE6]
          ena = bit_mask & rot_data; // [RULE6]
        end
      endcase
      next_vmem.wdata[p*8 +: 8] = (mode_data & ena) | (latch[p*8 +: 8] & ~ena); // [RULE7]
    end
    // odd/even replaces address bit 0 with offset bit 16, which is 0 outside the 128K window
    if (odd_even)
    begin
      next_vmem.addr = {off[16:1], off[16]}; // [RULE10]
      next_vmem.plane_en = cpu_req.addr[0] ? 4'hA : 4'h5; // [RULE11]
    end
    else
    begin
      next_vmem.addr = off; // [RULE9]
      next_vmem.plane_en = 4'hF;
    end
  end

  // registered so the plane request leaves straight from flops
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      vmem_q <= '0;
      hit_q <= 1'b0;
    end
    else
    begin
      vmem_q <= next_vmem;
      hit_q <= next_hit;
    end
  end

  assign vmem_req = vmem_q;
  assign cpu_hit = hit_q;
endmodule // pmw_core

// >>> pmw_core_chk.sv
// port checker for the planar memory write core
// assumes: bound to pmw_core; shadows index and misc from i/o writes
`timescale 1ns/1ps
module pmw_core_chk
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pmw_pkg::pmw_io_req_t io_req,
  input wire pmw_pkg::pmw_cpu_req_t cpu_req,
  input wire pmw_pkg::pmw_vmem_req_t vmem_req,
  input wire logic cpu_hit,
  input wire logic text_or_graphics_select
);
  import pmw_pkg::*;
  logic [7:0] idx;
  logic [3:0] misc;
  logic win;
  logic req;
  logic oe_hi_bit;
  // ==========================================================
  // shadow of index and misc, updated on the same edge as the core
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      {idx, misc} <= 12'h000;
    else if (io_req.wr && io_req.addr == 16'h03CE)
      idx <= io_req.wdata;
    else if (io_req.wr && io_req.addr == 16'h03CF && idx == 8'h06)
      misc <= io_req.wdata[3:0];
  end
  // window decode; codes 2 and 3 differ only in address bit 15
  assign win = (misc[3:2] == 2'h0) ? (cpu_req.addr[19:17] == 3'h5) :
    (misc[3:2] == 2'h1) ? (cpu_req.addr[19:16] == 4'hA) :
    (cpu_req.addr[19:15] == {4'hB, misc[2]});
  assign req = (cpu_req.wr || cpu_req.rd) && win;
  // offset bit 16 exists only in the 128K window; it replaces address bit 0
  assign oe_hi_bit = (misc[3:2] == 2'h0) && cpu_req.addr[16];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // properties
  property p_hit; req |=> cpu_hit && vmem_req.wr == $past(cpu_req.wr); endproperty
  a_hit: assert property (p_hit)
    else $error("window hit missing");
  property p_miss; (cpu_req.wr || cpu_req.rd) && !win |=> !(cpu_hit || vmem_req.wr); endproperty
  a_miss: assert property (p_miss)
    else $error("access outside window taken");
  property p_rd; cpu_req.rd && win |=> vmem_req.rd && !vmem_req.wr; endproperty
  a_rd: assert property (p_rd)
    else $error("plane read missing");
  property p_gms; text_or_graphics_select == misc[0]; endproperty
  a_gms: assert property (p_gms)
    else $error("text or graphics pin wrong");
  property p_flat; req && !misc[1] |=> vmem_req.plane_en == 4'hF &&
    vmem_req.addr[0] == $past(cpu_req.addr[0]); endproperty
  a_flat: assert property (p_flat)
    else $error("plain addressing wrong");
  property p_even; req && misc[1] && !cpu_req.addr[0] |=> vmem_req.plane_en == 4'h5; endproperty
  a_even: assert property (p_even)
    else $error("even maps not chosen");
  property p_odd; req && misc[1] && cpu_req.addr[0] |=> vmem_req.plane_en == 4'hA; endproperty
  a_odd: assert property (p_odd)
    else $error("odd maps not chosen");
  property p_oe_bit; req && misc[1] |=>
    vmem_req.addr[0] == $past(oe_hi_bit); endproperty
  a_oe_bit: assert property (p_oe_bit)
    else $error("odd/even address bit wrong");
endmodule // pmw_core_chk

// >>> pmw_plane_mem.sv
// plane memory model: answers each plane read one cycle later
// assumes: shares core_clk; data is meaningful only while valid
`timescale 1ns/1ps
module pmw_plane_mem
#(
  parameter logic [31:0] FILL = 32'hC3A55A3C
)
(
  input wire logic core_clk,
  input wire pmw_pkg::pmw_vmem_req_t vmem_req,
  output logic vmem_rvalid = 1'b0,
  output logic [31:0] vmem_rdata = 32'h0
);
  import pmw_pkg::*;
  // ==========================================================
  // data flips outside valid so stale data is never mistaken
  always @(posedge core_clk)
  begin
    vmem_rvalid <= vmem_req.rd;
    vmem_rdata <= vmem_req.rd ? FILL : ~vmem_rdata;
  end
endmodule // pmw_plane_mem

// >>> pmw_core_bench.sv
// bench for the planar memory write core
// assumes: checker and plane memory model compiled before it
`timescale 1ns/1ps
module pmw_core_bench;
  import pmw_pkg::*;
  localparam logic [31:0] FILL = 32'h96E1_3C5A;
  // register settings and cpu byte used by the write-mode scenario
  localparam logic [3:0] SR = 4'h5;
  localparam logic [3:0] SR_EN = 4'h3;
  localparam logic [7:0] ROT = 8'h01;
  localparam logic [7:0] MASK = 8'h3C;
  localparam logic [7:0] CPU_D = 8'h96;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  pmw_io_req_t io_req = '0;
  pmw_cpu_req_t cpu_req = '0;
  pmw_vmem_req_t vmem_req;
  logic [7:0] io_rdata;
  logic vmem_rvalid;
  logic [31:0] vmem_rdata;
  logic cpu_hit;
  logic text_or_graphics_select;
  int fails = 0;
  int cmp_count = 0;
  always #2.5 core_clk = ~core_clk;
  pmw_core u_pmw_core (.core_clk(core_clk), .rst_n(rst_n), .io_req(io_req),
    .io_rdata(io_rdata), .cpu_req(cpu_req), .vmem_rvalid(vmem_rvalid),
    .vmem_rdata(vmem_rdata), .vmem_req(vmem_req), .cpu_hit(cpu_hit),
    .text_or_graphics_select(text_or_graphics_select));
  pmw_plane_mem #(.FILL(FILL)) u_pmw_plane_mem (.core_clk(core_clk), .vmem_req(vmem_req),
    .vmem_rvalid(vmem_rvalid), .vmem_rdata(vmem_rdata));
  // ==========================================================
  // reporting
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // ==========================================================
  // bus cycles: request on an edge, released at the taking edge
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    io_req <= {w, ~w, a, d};
    @(posedge core_clk);
    io_req <= '0;
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    io(1'b1, 16'h03CE, i);
    io(1'b1, 16'h03CF, d);
  endtask
  task automatic cpu(input logic w, input logic [19:0] a);
    @(posedge core_clk);
    cpu_req <= {w, ~w, a, CPU_D};
    @(posedge core_clk);
    cpu_req <= '0;
    #1;
  endtask
  // plane data per mode, latches hold FILL
  function automatic logic [31:0] expw(input logic [1:0] m);
    logic [7:0] r;
    logic [7:0] v;
    logic [7:0] e;
    r = 8'({CPU_D, CPU_D} >> ROT[2:0]);
    for (int p = 0; p < 4; p++)
    begin
      v = (m == 2'h1) ? FILL[8*p+:8] : (m == 2'h2) ? {8{CPU_D[p]}} :
        (m == 2'h0 && !SR_EN[p]) ? r : {8{SR[p]}};
      e = (m == 2'h1) ? 8'hFF : (m == 2'h3) ? (MASK & r) : MASK;
      expw[8*p+:8] = (v & e) | (FILL[8*p+:8] & ~e);
    end
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_regs();
    reg_wr(8'h06, 8'hFF);
    io(1'b0, 16'h03CF, 8'h00);
    chk("misc readback", 32'h0F, {24'h0, io_rdata});
    chk("graphics select", 32'h1, {31'h0, text_or_graphics_select});
  endtask
  task automatic t_modes();
    reg_wr(8'h06, 8'h00);
    reg_wr(8'h00, {4'h0, SR});
    reg_wr(8'h01, {4'h0, SR_EN});
    reg_wr(8'h03, ROT);
    reg_wr(8'h08, MASK);
    cpu(1'b0, 20'hA0010);
    repeat (2) @(posedge core_clk);
    for (int m = 0; m < 4; m++)
    begin
      reg_wr(8'h05, 8'(m));
      cpu(1'b1, 20'hA0021);
      chk("plane data", expw(2'(m)), vmem_req.wdata);
    end
  endtask
  task automatic t_window();
    logic [19:0] hit_a [4] = '{20'hBFFFF, 20'hAFFFF, 20'hB7FFF, 20'hB8000};
    logic [19:0] miss_a [4] = '{20'h9FFFF, 20'hB0000, 20'hB8000, 20'hB7FFF};
    for (int m = 0; m < 4; m++)
    begin
      reg_wr(8'h06, {4'h0, 2'(m), 2'h2});
      cpu(1'b1, hit_a[m]);
      chk("window hit", 32'h1, {31'h0, cpu_hit});
      cpu(1'b0, miss_a[m]);
      chk("outside read", 32'h0, {31'h0, vmem_req.rd});
    end
    cpu(1'b1, 20'hB8006);
    chk("even map", 32'h65, {11'h0, vmem_req.addr, vmem_req.plane_en});
    reg_wr(8'h06, 8'h02);
    cpu(1'b1, 20'hB0001);
    chk("odd map", 32'h10001A, {11'h0, vmem_req.addr, vmem_req.plane_en});
    // odd address with offset bit 16 low: bit 0 must be replaced by 0
    cpu(1'b1, 20'hA0003);
    chk("odd low map", 32'h2A, {11'h0, vmem_req.addr, vmem_req.plane_en});
    reg_wr(8'h06, 8'h00);
    cpu(1'b1, 20'hA0001);
    chk("plain map", 32'h1F, {11'h0, vmem_req.addr, vmem_req.plane_en});
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_modes();
    t_window();
    finish_test();
  end
  // watchdog well past the hundred or so cycles the run needs
  initial
  begin
    repeat (3000) @(posedge core_clk);
    fails++;
    finish_test();
  end
endmodule // pmw_core_bench
bind pmw_core pmw_core_chk u_pmw_core_chk (.core_clk(core_clk), .rst_n(rst_n),
  .io_req(io_req), .cpu_req(cpu_req), .vmem_req(vmem_req), .cpu_hit(cpu_hit),
  .text_or_graphics_select(text_or_graphics_select));
